/* File: rtl/irq_ctrl_pkg.sv */
// package: constants, register map and types of the interrupt controller
package irq_ctrl_pkg;

  localparam int          PC_W      = 13;
  localparam int          NSRC      = 6;
  localparam int          STACK_D   = 4;
  localparam int          SP_W      = 3;

  // byte addresses on the register bus
  localparam logic [3:0]  ADR_EDGE  = 4'h0;
  localparam logic [3:0]  ADR_CTL0  = 4'h4;
  localparam logic [3:0]  ADR_CTL1  = 4'h8;
  localparam logic [3:0]  ADR_MFC   = 4'hc;

  // int_control_primary fields
  localparam int          B_GIE     = 0;
  localparam int          B_PINE    = 1;
  localparam int          B_TCHE    = 2;
  localparam int          B_GRPE    = 3;
  localparam int          B_PINF    = 4;
  localparam int          B_TCHF    = 5;
  localparam int          B_GRPF    = 6;
  // int_control_secondary fields
  localparam int          B_SERE    = 0;
  localparam int          B_TICKE   = 1;
  localparam int          B_NVME    = 2;
  localparam int          B_SERF    = 4;
  localparam int          B_TICKF   = 5;
  localparam int          B_NVMF    = 6;
  // multi_function_control fields
  localparam int          B_CPE     = 0;
  localparam int          B_CAE     = 1;
  localparam int          B_CPF     = 4;
  localparam int          B_CAF     = 5;

  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [1:0]  EDGE_OFF  = 2'h0;
  localparam logic [1:0]  EDGE_RISE = 2'h1;
  localparam logic [1:0]  EDGE_FALL = 2'h2;
  localparam logic [1:0]  EDGE_BOTH = 2'h3;

  // source index = priority, 0 highest
  localparam int          S_PIN     = 0;
  localparam int          S_TCH     = 1;
  localparam int          S_GRP     = 2;
  localparam int          S_TICK    = 3;
  localparam int          S_SER     = 4;
  localparam int          S_NVM     = 5;

  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_PUSH = 3'b010,
    ST_LOAD = 3'b100
  } seq_t;

endpackage : irq_ctrl_pkg

/* File: rtl/pin_edge_detect.sv */
// edge qualifier for the shared external interrupt pin
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect
  import irq_ctrl_pkg::*;
(
  input  wire logic       clk_sys,   // system clock
  input  wire logic       rst_n,     // async reset, active low
  input  wire logic       pinLevel,  // pin level, pull-high already applied
  input  wire logic       pinIsIn,   // port control says input
  input  wire logic       pinEn,     // pin interrupt enable
  input  wire logic [1:0] edgeSel,   // edge type field
  output logic            edgeHit    // one-cycle qualified edge
);
  logic prev_r;
  logic prev_nxt;
  logic hit_r;
  logic hit_nxt;
  logic rise;
  logic fall;

  always_comb begin
    prev_nxt = pinLevel;
    rise     = pinLevel & ~prev_r;
    fall     = ~pinLevel & prev_r;
    hit_nxt  = 1'b0;
    // pull-high stays with the pad; only the level is watched here
    if (pinEn && pinIsIn) begin
      case (edgeSel)
        EDGE_RISE: hit_nxt = rise;
        EDGE_FALL: hit_nxt = fall;
        EDGE_BOTH: hit_nxt = rise | fall;
        default:   hit_nxt = 1'b0;
      endcase
    end
  end

  // prev starts high so a pulled-up pin gives no false rise after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
      hit_r  <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      hit_r  <= hit_nxt;
    end
  end

  assign edgeHit = hit_r;

  a_edge_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (edgeSel == EDGE_OFF || !pinIsIn) |=> !hit_r)
    else $error("edge reported while pin irq disabled");
endmodule : pin_edge_detect
`default_nettype wire

/* File: rtl/return_stack.sv */
// return address stack for interrupt entry and return
`timescale 1ns/100ps
`default_nettype none
module return_stack
  import irq_ctrl_pkg::*;
(
  input  wire logic            clk_sys,  // system clock
  input  wire logic            rst_n,    // async reset, active low
  input  wire logic            push,     // push pushData
  input  wire logic            pop,      // pop top entry
  input  wire logic [PC_W-1:0] pushData, // address to save
  output logic      [PC_W-1:0] top,      // current top entry
  output logic                 full,     // no room left
  output logic      [SP_W-1:0] depth     // entries held
);
  logic [PC_W-1:0] mem_r [STACK_D];
  logic [PC_W-1:0] mem_nxt [STACK_D];
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_nxt;

  always_comb begin
    mem_nxt = mem_r;
    sp_nxt  = sp_r;
    if (push && !full) begin
      mem_nxt[sp_r[1:0]] = pushData;
      sp_nxt = sp_r + 3'h1;
    end else if (pop && sp_r != 3'h0) begin
      sp_nxt = sp_r - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= 3'h0;
      for (int i = 0; i < STACK_D; i++) mem_r[i] <= '0;
    end else begin
      sp_r  <= sp_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign full  = (sp_r == SP_W'(STACK_D));
  assign depth = sp_r;
  assign top   = mem_r[2'(sp_r - 3'h1)];
endmodule : return_stack
`default_nettype wire

/* File: rtl/irq_ctrl.sv */
// interrupt controller top: register file, flags, arbiter, pc sequencing
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_PIN  = 13'h0004,
  parameter logic [PC_W-1:0] VEC_TCH  = 13'h0008,
  parameter logic [PC_W-1:0] VEC_GRP  = 13'h000c,
  parameter logic [PC_W-1:0] VEC_TICK = 13'h0010,
  parameter logic [PC_W-1:0] VEC_SER  = 13'h0014,
  parameter logic [PC_W-1:0] VEC_NVM  = 13'h0018
)(
  input  wire logic            clk_sys,     // system clock
  input  wire logic            rst_n,       // async reset, active low
  input  wire logic [3:0]      s_awaddr,    // axi write address
  input  wire logic            s_awvalid,   // axi
  output logic                 s_awready,   // axi
  input  wire logic [31:0]     s_wdata,     // axi write data
  input  wire logic [3:0]      s_wstrb,     // axi byte strobes
  input  wire logic            s_wvalid,    // axi
  output logic                 s_wready,    // axi
  output logic [1:0]           s_bresp,     // axi
  output logic                 s_bvalid,    // axi
  input  wire logic            s_bready,    // axi
  input  wire logic [3:0]      s_araddr,    // axi read address
  input  wire logic            s_arvalid,   // axi
  output logic                 s_arready,   // axi
  output logic [31:0]          s_rdata,     // axi read data
  output logic [1:0]           s_rresp,     // axi
  output logic                 s_rvalid,    // axi
  input  wire logic            s_rready,    // axi
  input  wire logic            pinLevel,    // external interrupt pin level
  input  wire logic            pinIsIn,     // port control: pin is input
  input  wire logic            touchEvt,    // touch slot counter overflow
  input  wire logic            tickEvt,     // time base overflow
  input  wire logic            serialEvt,   // serial module event
  input  wire logic            nvmEvt,      // nvm write cycle end
  input  wire logic            cmpPEvt,     // comparator p match
  input  wire logic            cmpAEvt,     // comparator a match
  input  wire logic            instrBound,  // core may take an irq now
  input  wire logic [PC_W-1:0] nextPc,      // next instruction address
  input  wire logic            retiExec,    // return_from_irq_instr executes
  output logic                 pcLoad,      // load pcValue into pc
  output logic [PC_W-1:0]      pcValue,     // vector or return address
  output logic                 irqTaken,    // entry sequence begun
  output logic                 stackFull,   // return stack full
  output logic                 wake         // leave sleep or idle
);
  logic [1:0]      edge_r, edge_nxt;
  logic [7:0]      ctl0_r, ctl0_nxt;
  logic [7:0]      ctl1_r, ctl1_nxt;
  logic [7:0]      mfc_r, mfc_nxt;
  seq_t            st_r, st_nxt;
  logic [2:0]      src_r, src_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic            pcLd_r, pcLd_nxt, tk_r, tk_nxt, wake_r, wake_nxt;
  logic            awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [3:0]      awA_r, awA_nxt;
  logic [31:0]     wD_r, wD_nxt;
  logic [3:0]      wS_r, wS_nxt;
  logic            bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0]      br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0]     rd_r, rd_nxt;
  logic            full_r, full_nxt;

  logic            pinHit, stkFull, doWr, doRd, accept, push, pop;
  logic [SP_W-1:0] depth;
  logic [PC_W-1:0] stkTop;
  logic [NSRC-1:0] flags, enables, pend;
  logic [2:0]      win;
  logic [7:0]      rdByte;

  pin_edge_detect u_edge (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinLevel(pinLevel),
    .pinIsIn (pinIsIn),
    .pinEn   (ctl0_r[B_PINE]),
    .edgeSel (edge_r),
    .edgeHit (pinHit)
  );

  return_stack u_stack (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .push    (push),
    .pop     (pop),
    .pushData(nextPc),
    .top     (stkTop),
    .full    (stkFull),
    .depth   (depth)
  );

  // priority order is the bit order
  assign flags   = {ctl1_r[B_NVMF], ctl1_r[B_SERF], ctl1_r[B_TICKF],
                    ctl0_r[B_GRPF], ctl0_r[B_TCHF], ctl0_r[B_PINF]};
  assign enables = {ctl1_r[B_NVME], ctl1_r[B_SERE], ctl1_r[B_TICKE],
                    ctl0_r[B_GRPE], ctl0_r[B_TCHE], ctl0_r[B_PINE]};
  assign pend    = flags & enables;

  always_comb begin
    win = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) win = 3'(i);
    end
  end

  assign accept = (st_r == ST_RUN) && instrBound && ctl0_r[B_GIE] && (|pend) && !stkFull;
  assign push   = (st_r == ST_PUSH);
  // a return that loses to an entry must not pop, or stack and pc drift apart
  assign pop    = (st_r == ST_RUN) && !accept && retiExec;

  // axi: take address and data in either order, one write at a time
  assign doWr = awHeld_r && wHeld_r && !bv_r;
  assign doRd = s_arvalid && !rv_r;

  always_comb begin
    case (s_araddr)
      ADR_EDGE: rdByte = {6'h00, edge_r};
      ADR_CTL0: rdByte = {1'b0, ctl0_r[6:0]};
      ADR_CTL1: rdByte = {1'b0, ctl1_r[6:4], 1'b0, ctl1_r[2:0]};
      ADR_MFC:  rdByte = {2'h0, mfc_r[5:4], 2'h0, mfc_r[1:0]};
      default:  rdByte = 8'h00;
    endcase
  end

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    awA_nxt    = awA_r;
    wD_nxt     = wD_r;
    wS_nxt     = wS_r;
    bv_nxt     = bv_r;
    br_nxt     = br_r;
    rv_nxt     = rv_r;
    rr_nxt     = rr_r;
    rd_nxt     = rd_r;
    if (s_awvalid && !awHeld_r) begin
      awHeld_nxt = 1'b1;
      awA_nxt    = s_awaddr;
    end
    if (s_wvalid && !wHeld_r) begin
      wHeld_nxt = 1'b1;
      wD_nxt    = s_wdata;
      wS_nxt    = s_wstrb;
    end
    if (doWr) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bv_nxt     = 1'b1;
      br_nxt     = (awA_r[1:0] == 2'h0) ? RESP_OK : RESP_SLV;
    end
    if (bv_r && s_bready) bv_nxt = 1'b0;
    if (doRd) begin
      rv_nxt = 1'b1;
      rd_nxt = {24'h000000, rdByte};
      rr_nxt = (s_araddr[1:0] == 2'h0) ? RESP_OK : RESP_SLV;
    end else if (rv_r && s_rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_comb begin
    edge_nxt = edge_r;
    ctl0_nxt = ctl0_r;
    ctl1_nxt = ctl1_r;
    mfc_nxt  = mfc_r;
    // software writes first, so hardware sets below win over clears
    if (doWr && wS_r[0]) begin
      case (awA_r)
        ADR_EDGE: edge_nxt = wD_r[1:0];
        ADR_CTL0: ctl0_nxt = {1'b0, wD_r[6:0]};
        ADR_CTL1: ctl1_nxt = {1'b0, wD_r[6:4], 1'b0, wD_r[2:0]};
        ADR_MFC:  mfc_nxt  = {2'h0, wD_r[5:4], 2'h0, wD_r[1:0]};
        default:  ;
      endcase
    end
    if (accept) begin
      ctl0_nxt[B_GIE] = 1'b0;
      case (win)
        3'(S_PIN):  ctl0_nxt[B_PINF]  = 1'b0;
        3'(S_TCH):  ctl0_nxt[B_TCHF]  = 1'b0;
        3'(S_GRP):  ctl0_nxt[B_GRPF]  = 1'b0;
        3'(S_TICK): ctl1_nxt[B_TICKF] = 1'b0;
        3'(S_SER):  ctl1_nxt[B_SERF]  = 1'b0;
        3'(S_NVM):  ctl1_nxt[B_NVMF]  = 1'b0;
        default:    ;
      endcase
    end
    // events set flags regardless of global enable, and of their enables except the pin edge, which is gated by B_PINE
    if (pinHit)    ctl0_nxt[B_PINF]  = 1'b1;
    if (touchEvt)  ctl0_nxt[B_TCHF]  = 1'b1;
    if (tickEvt)   ctl1_nxt[B_TICKF] = 1'b1;
    if (serialEvt) ctl1_nxt[B_SERF]  = 1'b1;
    if (nvmEvt)    ctl1_nxt[B_NVMF]  = 1'b1;
    if (cmpPEvt)   mfc_nxt[B_CPF]    = 1'b1;
    if (cmpAEvt)   mfc_nxt[B_CAF]    = 1'b1;
    // enabled comparator events raise the grouped flag
    if ((cmpPEvt && mfc_r[B_CPE]) || (cmpAEvt && mfc_r[B_CAE]))
      ctl0_nxt[B_GRPF] = 1'b1;
  end

  always_comb begin
    st_nxt   = st_r;
    src_nxt  = src_r;
    pc_nxt   = pc_r;
    pcLd_nxt = 1'b0;
    tk_nxt   = 1'b0;
    wake_nxt = |{ctl0_r[B_PINF], ctl0_r[B_TCHF], ctl0_r[B_GRPF], ctl1_r[B_TICKF],
                 ctl1_r[B_SERF], ctl1_r[B_NVMF], mfc_r[B_CPF], mfc_r[B_CAF]};
    full_nxt = stkFull;
    case (st_r)
      ST_RUN: begin
        if (accept) begin
          st_nxt  = ST_PUSH;
          src_nxt = win;
          tk_nxt  = 1'b1;
        end else if (retiExec) begin
          pc_nxt   = stkTop;
          pcLd_nxt = 1'b1;
        end
      end
      ST_PUSH: st_nxt = ST_LOAD;
      ST_LOAD: begin
        // comparators have no vector of their own
        case (src_r)
          3'(S_PIN):  pc_nxt = VEC_PIN;
          3'(S_TCH):  pc_nxt = VEC_TCH;
          3'(S_GRP):  pc_nxt = VEC_GRP;
          3'(S_TICK): pc_nxt = VEC_TICK;
          3'(S_SER):  pc_nxt = VEC_SER;
          default:    pc_nxt = VEC_NVM;
        endcase
        pcLd_nxt = 1'b1;
        st_nxt   = ST_RUN;
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edge_r <= EDGE_OFF;
      ctl0_r <= REG_RST;
      ctl1_r <= REG_RST;
      mfc_r  <= REG_RST;
      st_r   <= ST_RUN;
      src_r  <= 3'h0;
      pc_r   <= '0;
      pcLd_r <= 1'b0;
      tk_r   <= 1'b0;
      wake_r <= 1'b0;
      full_r <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awA_r  <= 4'h0;
      wD_r   <= 32'h00000000;
      wS_r   <= 4'h0;
      bv_r   <= 1'b0;
      br_r   <= RESP_OK;
      rv_r   <= 1'b0;
      rr_r   <= RESP_OK;
      rd_r   <= 32'h00000000;
    end else begin
      edge_r <= edge_nxt;
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      mfc_r  <= mfc_nxt;
      st_r   <= st_nxt;
      src_r  <= src_nxt;
      pc_r   <= pc_nxt;
      pcLd_r <= pcLd_nxt;
      tk_r   <= tk_nxt;
      wake_r <= wake_nxt;
      full_r <= full_nxt;
      awHeld_r <= awHeld_nxt;
      wHeld_r  <= wHeld_nxt;
      awA_r  <= awA_nxt;
      wD_r   <= wD_nxt;
      wS_r   <= wS_nxt;
      bv_r   <= bv_nxt;
      br_r   <= br_nxt;
      rv_r   <= rv_nxt;
      rr_r   <= rr_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign s_awready = !awHeld_r;
  assign s_wready  = !wHeld_r;
  assign s_bvalid  = bv_r;
  assign s_bresp   = br_r;
  assign s_arready = !rv_r;
  assign s_rvalid  = rv_r;
  assign s_rresp   = rr_r;
  assign s_rdata   = rd_r;
  assign pcLoad    = pcLd_r;
  assign pcValue   = pc_r;
  assign irqTaken  = tk_r;
  assign stackFull = full_r;
  assign wake      = wake_r;

  a_gie_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctl0_r[B_GIE] |=> !tk_r)
    else $error("irq taken with global enable low");
  a_full_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stkFull |=> !tk_r)
    else $error("irq taken with stack full");
  a_taken_gie_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept |=> !ctl0_r[B_GIE] || $past(doWr))
    else $error("global enable not cleared on entry");
  a_vector_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tk_r |=> ##1 pcLd_r)
    else $error("vector not loaded two cycles after entry");
  a_push_depth: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_PUSH && !retiExec) |=> depth == $past(depth) + 3'h1)
    else $error("return address not pushed");
  a_pin_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pinHit |=> ctl0_r[B_PINF])
    else $error("pin edge lost");
  a_disabled_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctl0_r[B_PINF] && !ctl0_r[B_PINE] && !doWr) |=> ctl0_r[B_PINF])
    else $error("disabled flag cleared by hardware");
  a_grp_keeps_cmp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (accept && win == 3'(S_GRP) && mfc_r[B_CPF] && !doWr) |=> mfc_r[B_CPF])
    else $error("comparator flag cleared on grouped service");
  a_wake_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl1_r[B_NVMF] |=> wake_r)
    else $error("no wake on pending flag");
  a_one_at_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tk_r |=> !tk_r [*2])
    else $error("two entries too close");

  c_pin_irq: cover property (@(posedge clk_sys) disable iff (!rst_n)
    tk_r && src_r == 3'(S_PIN));
  c_grp_irq: cover property (@(posedge clk_sys) disable iff (!rst_n)
    tk_r && src_r == 3'(S_GRP));
  c_return: cover property (@(posedge clk_sys) disable iff (!rst_n)
    retiExec && st_r == ST_RUN && depth != 3'h0);
  c_full_hold: cover property (@(posedge clk_sys) disable iff (!rst_n)
    stkFull && |pend && ctl0_r[B_GIE]);
endmodule : irq_ctrl
`default_nettype wire

/* File: sim/core_model.sv */
// processor core stand-in: fetch address, irq windows, return pulses
`timescale 1ns/100ps
`default_nettype none
module core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic            clk_sys,    // system clock
  input  wire logic            rst_n,      // async reset, active low
  input  wire logic            slow,       // stall: no irq windows
  input  wire logic            retReq,     // bench asks for a return
  input  wire logic            irqTaken,   // entry begun
  input  wire logic            pcLoad,     // load pcValue
  input  wire logic [PC_W-1:0] pcValue,    // vector or return address
  output logic                 instrBound, // irq may be taken
  output logic      [PC_W-1:0] nextPc,     // next fetch address
  output logic                 retiExec    // return instruction pulse
);
  logic            busy_r;
  logic            busy_nxt;
  logic [PC_W-1:0] pc_nxt;

  // fetch frozen from entry until the vector load, so the pushed address is stable
  always_comb begin
    busy_nxt = (busy_r | irqTaken) & ~pcLoad;
    pc_nxt   = pcLoad ? pcValue : ((busy_nxt | slow) ? nextPc : nextPc + 13'h1);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r     <= 1'b0;
      nextPc     <= 13'h100;
      instrBound <= 1'b0;
      retiExec   <= 1'b0;
    end else begin
      busy_r     <= busy_nxt;
      nextPc     <= pc_nxt;
      instrBound <= ~busy_nxt & ~slow;
      retiExec   <= retReq & ~busy_nxt;
    end
  end
endmodule : core_model
`default_nettype wire

/* File: sim/mcu_interrupt_controller_tb.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module mcu_interrupt_controller_tb
  import irq_ctrl_pkg::*;
;
  localparam logic [PC_W-1:0] VEC [6] = '{13'h0a0, 13'h0a4, 13'h0a8, 13'h0ac, 13'h0b0, 13'h0b4};
  logic            clk_sys   = 1'b0;
  logic            rst_n     = 1'b0;
  logic [3:0]      s_awaddr  = 4'h0;
  logic [3:0]      s_araddr  = 4'h0;
  logic [3:0]      s_wstrb   = 4'hf;
  logic [31:0]     s_wdata   = 32'h0;
  logic            s_awvalid = 1'b0;
  logic            s_wvalid  = 1'b0;
  logic            s_bready  = 1'b0;
  logic            s_arvalid = 1'b0;
  logic            s_rready  = 1'b0;
  logic            pinLevel  = 1'b1;
  logic            pinIsIn   = 1'b1;
  logic            slow      = 1'b0;
  logic            retReq    = 1'b0;
  logic [5:0]      evt       = 6'h0;
  logic            s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]      s_bresp, s_rresp, lastResp;
  logic [31:0]     s_rdata;
  logic            instrBound, retiExec, pcLoad, irqTaken, stackFull, wake;
  logic [PC_W-1:0] nextPc, pcValue;
  logic [PC_W-1:0] retQ [$];
  int              takes = 0, cyc = 0, errTotal = 0, compares = 0;

  irq_ctrl #(.VEC_PIN(VEC[0]), .VEC_TCH(VEC[1]), .VEC_GRP(VEC[2]), .VEC_TICK(VEC[3]),
    .VEC_SER(VEC[4]), .VEC_NVM(VEC[5])) DUT (
    .clk_sys, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pinLevel, .pinIsIn, .touchEvt(evt[0]),
    .tickEvt(evt[1]), .serialEvt(evt[2]), .nvmEvt(evt[3]), .cmpPEvt(evt[4]),
    .cmpAEvt(evt[5]), .instrBound, .nextPc, .retiExec, .pcLoad, .pcValue, .irqTaken,
    .stackFull, .wake);
  core_model CORE (.clk_sys, .rst_n, .slow, .retReq, .irqTaken, .pcLoad, .pcValue,
    .instrBound, .nextPc, .retiExec);

  initial forever #25 clk_sys = ~clk_sys;

  // return addresses as the core offered them at each entry
  always @(posedge clk_sys) begin
    cyc++;
    if (irqTaken === 1'b1) begin
      takes++;
      retQ.push_back(nextPc);
    end
    if (cyc == 20000) begin
      errTotal++;
      $display("Error %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // bus waits have no limit of their own: the cycle ceiling ends a hang
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= {24'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    lastResp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    lastResp = s_rresp;
    s_rready <= 1'b0;
  endtask : rd

  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e, "register read");
  endtask : rdChk

  task automatic setGlobal();
    logic [31:0] d;
    rd(ADR_CTL0, d);
    wr(ADR_CTL0, d[7:0] | 8'h01);
  endtask : setGlobal

  task automatic fire(input logic [5:0] m);
    @(posedge clk_sys);
    evt <= m;
    @(posedge clk_sys);
    evt <= 6'h0;
  endtask : fire

  task automatic pin(input logic l);
    @(posedge clk_sys);
    pinLevel <= l;
    idle(3);
  endtask : pin

  task automatic waitLoad(output logic [PC_W-1:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pcLoad !== 1'b1 && n < 60);
    v = (pcLoad === 1'b1) ? pcValue : 'x;
  endtask : waitLoad

  task automatic return_from_irq_instr();
    logic [PC_W-1:0] v;
    @(posedge clk_sys);
    retReq <= 1'b1;
    @(posedge clk_sys);
    retReq <= 1'b0;
    waitLoad(v);
    chk(32'(v), 32'(retQ.pop_back()), "return address");
  endtask : return_from_irq_instr

  task automatic t_regs();
    rdChk(ADR_EDGE, 32'h0);
    rdChk(ADR_CTL0, 32'h0);
    rdChk(ADR_CTL1, 32'h0);
    rdChk(ADR_MFC, 32'h0);
    chk(32'(lastResp), 32'(RESP_OK), "read response");
    wr(ADR_EDGE, 8'hff);
    chk(32'(lastResp), 32'(RESP_OK), "write response");
    rdChk(ADR_EDGE, 32'h3);
    wr(4'h2, 8'h01);
    chk(32'(lastResp), 32'(RESP_SLV), "unaligned write");
    rdChk(4'h2, 32'h0);
    chk(32'(lastResp), 32'(RESP_SLV), "unaligned read");
    // low byte lane off: the write must be dropped
    s_wstrb <= 4'he;
    wr(ADR_EDGE, 8'h00);
    s_wstrb <= 4'hf;
    rdChk(ADR_EDGE, 32'h3);
    $display("done: registers");
  endtask : t_regs

  task automatic t_mask();
    int t0;
    t0 = takes;
    wr(ADR_CTL0, 8'h01);
    fire(6'h01);
    rdChk(ADR_CTL0, 32'h21);
    chk(32'(wake), 32'h1, "wake");
    wr(ADR_CTL0, 8'h24);
    idle(6);
    chk(32'(takes), 32'(t0), "blocked take");
    wr(ADR_CTL0, 8'h00);
    idle(2);
    chk(32'(wake), 32'h0, "wake with no flag");
    $display("done: masking");
  endtask : t_mask

  task automatic t_pin();
    logic [PC_W-1:0] v;
    int t0;
    for (int m = 0; m < 4; m++) begin
      wr(ADR_EDGE, 8'(m));
      wr(ADR_CTL0, 8'h02);
      pin(1'b0);
      rdChk(ADR_CTL0, m[1] ? 32'h12 : 32'h02);
      wr(ADR_CTL0, 8'h02);
      pin(1'b1);
      rdChk(ADR_CTL0, m[0] ? 32'h12 : 32'h02);
    end
    wr(ADR_CTL0, 8'h02);
    pinIsIn <= 1'b0;
    pin(1'b0);
    pin(1'b1);
    rdChk(ADR_CTL0, 32'h02);
    pinIsIn <= 1'b1;
    wr(ADR_EDGE, 8'h01);
    wr(ADR_CTL0, 8'h03);
    t0 = takes;
    slow <= 1'b1;
    pin(1'b0);
    pin(1'b1);
    chk(32'(takes), 32'(t0), "stalled core");
    slow <= 1'b0;
    waitLoad(v);
    chk(32'(v), 32'(VEC[S_PIN]), "pin vector");
    rdChk(ADR_CTL0, 32'h02);
    return_from_irq_instr();
    $display("done: pin edges");
  endtask : t_pin

  task automatic t_prio();
    logic [PC_W-1:0] v;
    int ord [5] = '{S_TCH, S_GRP, S_TICK, S_SER, S_NVM};
    wr(ADR_CTL1, 8'h07);
    wr(ADR_MFC, 8'h01);
    wr(ADR_CTL0, 8'h0c);
    fire(6'h3f);
    rdChk(ADR_MFC, 32'h31);
    rdChk(ADR_CTL0, 32'h6c);
    rdChk(ADR_CTL1, 32'h77);
    for (int i = 0; i < 5; i++) begin
      setGlobal();
      waitLoad(v);
      chk(32'(v), 32'(VEC[ord[i]]), "priority vector");
      return_from_irq_instr();
    end
    rdChk(ADR_MFC, 32'h31);
    rdChk(ADR_CTL0, 32'h0c);
    rdChk(ADR_CTL1, 32'h07);
    wr(ADR_CTL0, 8'h00);
    wr(ADR_MFC, 8'h00);
    $display("done: priority");
  endtask : t_prio

  task automatic t_stack();
    logic [PC_W-1:0] v;
    int t0;
    wr(ADR_CTL1, 8'h01);
    repeat (4) begin
      fire(6'h04);
      setGlobal();
      waitLoad(v);
      chk(32'(v), 32'(VEC[S_SER]), "serial vector");
    end
    chk(32'(stackFull), 32'h1, "stack full");
    t0 = takes;
    fire(6'h04);
    setGlobal();
    idle(8);
    chk(32'(takes), 32'(t0), "take while full");
    return_from_irq_instr();
    waitLoad(v);
    chk(32'(v), 32'(VEC[S_SER]), "late vector");
    repeat (4) return_from_irq_instr();
    $display("done: stack");
  endtask : t_stack

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_mask();
    t_pin();
    t_prio();
    t_stack();
    print_verdict();
  end
endmodule : mcu_interrupt_controller_tb
`default_nettype wire
